//--- hw/eas_sequencer.sv
// eas_sequencer: event/action sequencer of a motor drive, with AXI4-Lite registers.
// assumes start/stop, zero-speed, on-reference and external event come from pins
// outside the clock domain; the AXI master sits on CLK_I.
`timescale 1ns/1ps
// Operation
// - events and actions pair by number; true event n runs action n, then n+1.
// - one event tested per scan; false means no action and index kept.
// - on start the sequencer begins at pair one and tests only that event.
// - programmed pair count may be anything from zero to twenty.
// - after the last programmed pair executes, wrap back to the first event.
// - event codes: 0 false, 1 true, 4 on reference, 30 timer zero expired.
// - action codes: 1 none, 10 preset zero, 11 preset one, 29 start timer.
// - timer zero runs a programmed duration; expiry makes timeout event true.
// - preset action switches active reference to that preset percentage.
// - with mode off, no event is tested and no action executed.
// - events come from internal conditions or from external signals.
// - stop command ramps motor down, then drive enters free unpowered state.
module eas_sequencer import eas_pkg::*; #(
  parameter int SCAN_CNT = SCAN_CYCLES
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // axi4-lite write
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // axi4-lite read
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // drive pins
  input wire logic START_I,
  input wire logic ZERO_SPEED_I,
  input wire logic ON_REF_I,
  input wire logic EXT_EVENT_I,
  output eas_drive_s DRV_O
);
  localparam int SCAN_W = $clog2(SCAN_CNT + 1);

  // two-stage synchronisers for the four pins
  logic [3:0] sync1_r, sync2_r;
  logic start_s, zspd_s, onref_s, ext_s;
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {EXT_EVENT_I, ON_REF_I, ZERO_SPEED_I, START_I};
      sync2_r <= sync1_r;
    end
  end
  assign {ext_s, onref_s, zspd_s, start_s} = sync2_r;

  // register state
  logic en_r, en_nxt;
  logic [IDX_W-1:0] cnt_r, cnt_nxt;
  logic [TMR_W-1:0] dur_r, dur_nxt;
  logic [PCT_W-1:0] pre0_r, pre0_nxt, pre1_r, pre1_nxt;
  logic [SEL_W-1:0] ev_sel_r [MAX_PAIRS];
  logic [SEL_W-1:0] ev_sel_nxt [MAX_PAIRS];
  logic [SEL_W-1:0] act_sel_r [MAX_PAIRS];
  logic [SEL_W-1:0] act_sel_nxt [MAX_PAIRS];
  // bus handshake state
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, arrdy_r, arrdy_nxt;
  // sequencer state
  logic [SCAN_W-1:0] scan_r, scan_nxt;
  logic tick_r, tick_nxt;
  logic [IDX_W-1:0] idx_r, idx_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  logic tmr_run_r, tmr_run_nxt, tmr_exp_r, tmr_exp_nxt;
  logic psel_r, psel_nxt;
  eas_motor_e ms_r, ms_nxt;
  eas_drive_s drv_r, drv_nxt;
  logic ev_true, fire;
  logic [SEL_W-1:0] cur_ev, cur_act;

  // register write and read decode; a write lands only when address and data are both held
  always_comb begin
    logic do_wr;
    logic [7:0] wa;
    do_wr = 1'b0;
    wa = 8'h00;
    en_nxt = en_r;
    cnt_nxt = cnt_r;
    dur_nxt = dur_r;
    pre0_nxt = pre0_r;
    pre1_nxt = pre1_r;
    ev_sel_nxt = ev_sel_r;
    act_sel_nxt = act_sel_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (AWVALID_I && awrdy_r) begin
      aw_got_nxt = 1'b1;
      aw_addr_nxt = AWADDR_I;
    end
    if (WVALID_I && wrdy_r) begin
      w_got_nxt = 1'b1;
      w_data_nxt = WDATA_I;
      w_strb_nxt = WSTRB_I;
    end
    if (bvalid_r && BREADY_I) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_got_r && w_got_r && !bvalid_r) begin
      do_wr = 1'b1;
      wa = aw_addr_r;
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_SLVERR;
    end
    if (do_wr) begin
      if (wa == OFS_CTRL) begin
        bresp_nxt = RESP_OKAY;
        if (w_strb_r[0]) en_nxt = w_data_r[CTRL_EN_BIT];
        if (w_strb_r[1]) begin
          cnt_nxt = (w_data_r[CTRL_CNT_LSB +: IDX_W] > IDX_W'(MAX_PAIRS)) ?
            IDX_W'(MAX_PAIRS) : w_data_r[CTRL_CNT_LSB +: IDX_W];
        end
      end else if (wa == OFS_TIMER0) begin
        bresp_nxt = RESP_OKAY;
        if (w_strb_r[0]) dur_nxt[7:0] = w_data_r[7:0];
        if (w_strb_r[1]) dur_nxt[15:8] = w_data_r[15:8];
      end else if (wa == OFS_PRESET0) begin
        bresp_nxt = RESP_OKAY;
        if (w_strb_r[0]) pre0_nxt = w_data_r[PCT_W-1:0];
      end else if (wa == OFS_PRESET1) begin
        bresp_nxt = RESP_OKAY;
        if (w_strb_r[0]) pre1_nxt = w_data_r[PCT_W-1:0];
      end else if (wa == OFS_STATUS) begin
        bresp_nxt = RESP_OKAY;
      end
      for (int i = 0; i < MAX_PAIRS; i++) begin
        if (wa == OFS_EVENT_BASE + 8'(4 * i)) begin
          bresp_nxt = RESP_OKAY;
          if (w_strb_r[0]) ev_sel_nxt[i] = w_data_r[SEL_W-1:0];
        end
        if (wa == OFS_ACTION_BASE + 8'(4 * i)) begin
          bresp_nxt = RESP_OKAY;
          if (w_strb_r[0]) act_sel_nxt[i] = w_data_r[SEL_W-1:0];
        end
      end
    end
    if (rvalid_r && RREADY_I) begin
      rvalid_nxt = 1'b0;
    end
    if (ARVALID_I && arrdy_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      case (ARADDR_I)
        OFS_CTRL: begin
          rdata_nxt[CTRL_EN_BIT] = en_r;
          rdata_nxt[CTRL_CNT_LSB +: IDX_W] = cnt_r;
        end
        OFS_TIMER0: rdata_nxt[TMR_W-1:0] = dur_r;
        OFS_PRESET0: rdata_nxt[PCT_W-1:0] = pre0_r;
        OFS_PRESET1: rdata_nxt[PCT_W-1:0] = pre1_r;
        OFS_STATUS: begin
          rdata_nxt[ST_IDX_LSB +: IDX_W] = idx_r;
          rdata_nxt[ST_TMR_RUN_BIT] = tmr_run_r;
          rdata_nxt[ST_TMR_EXP_BIT] = tmr_exp_r;
          rdata_nxt[ST_PRESET_BIT] = psel_r;
          rdata_nxt[ST_MOTOR_LSB +: 3] = ms_r;
        end
        default: begin
          rresp_nxt = RESP_SLVERR;
          for (int i = 0; i < MAX_PAIRS; i++) begin
            if (ARADDR_I == OFS_EVENT_BASE + 8'(4 * i)) begin
              rresp_nxt = RESP_OKAY;
              rdata_nxt[SEL_W-1:0] = ev_sel_r[i];
            end
            if (ARADDR_I == OFS_ACTION_BASE + 8'(4 * i)) begin
              rresp_nxt = RESP_OKAY;
              rdata_nxt[SEL_W-1:0] = act_sel_r[i];
            end
          end
        end
      endcase
    end
    // ready flags registered so every bus output comes from a flop
    awrdy_nxt = !aw_got_nxt && !bvalid_nxt;
    wrdy_nxt = !w_got_nxt && !bvalid_nxt;
    arrdy_nxt = !rvalid_nxt;
  end

  // register and bus flops
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      en_r <= 1'b0;
      cnt_r <= '0;
      dur_r <= RST_TIMER0;
      pre0_r <= RST_PRESET;
      pre1_r <= RST_PRESET;
      for (int i = 0; i < MAX_PAIRS; i++) begin
        ev_sel_r[i] <= RST_EVENT;
        act_sel_r[i] <= RST_ACTION;
      end
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      awrdy_r <= 1'b0;
      wrdy_r <= 1'b0;
      arrdy_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
      cnt_r <= cnt_nxt;
      dur_r <= dur_nxt;
      pre0_r <= pre0_nxt;
      pre1_r <= pre1_nxt;
      ev_sel_r <= ev_sel_nxt;
      act_sel_r <= act_sel_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      awrdy_r <= awrdy_nxt;
      wrdy_r <= wrdy_nxt;
      arrdy_r <= arrdy_nxt;
    end
  end

  // current pair lookup; index stays below MAX_PAIRS, so the array read is in range
  assign cur_ev = ev_sel_r[idx_r];
  assign cur_act = act_sel_r[idx_r];

  // constants, internal timer, or the synchronised on-reference and external pins
  always_comb begin
    case (cur_ev)
      EV_FALSE: ev_true = 1'b0;
      EV_TRUE: ev_true = 1'b1;
      EV_EXT_IN: ev_true = ext_s;
      EV_ON_REF: ev_true = onref_s;
      EV_TIMEOUT0: ev_true = tmr_exp_r;
      default: ev_true = 1'b0;
    endcase
  end

  assign fire = tick_r && en_r && (cnt_r != '0) && ev_true;

  // sequencer, timer and motor next state
  always_comb begin
    scan_nxt = scan_r + SCAN_W'(1);
    tick_nxt = 1'b0;
    idx_nxt = idx_r;
    tmr_nxt = tmr_r;
    tmr_run_nxt = tmr_run_r;
    tmr_exp_nxt = tmr_exp_r;
    psel_nxt = psel_r;
    ms_nxt = ms_r;
    if (scan_r == SCAN_W'(SCAN_CNT - 1)) begin
      scan_nxt = '0;
      tick_nxt = 1'b1;
    end
    if (tmr_run_r && tick_r) begin
      if (tmr_r <= TMR_W'(1)) begin
        tmr_run_nxt = 1'b0;
        tmr_exp_nxt = 1'b1;
        tmr_nxt = '0;
      end else begin
        tmr_nxt = tmr_r - TMR_W'(1);
      end
    end
    // mode off parks at first pair
    if (!en_r || (idx_r >= cnt_r)) begin
      idx_nxt = '0;
    end else if (fire) begin
      // run action n, step to n+1
      idx_nxt = (idx_r == cnt_r - IDX_W'(1)) ? '0 : idx_r + IDX_W'(1);
      case (cur_act)
        ACT_PRESET0: psel_nxt = 1'b0;
        ACT_PRESET1: psel_nxt = 1'b1;
        // start wins over expiry in the same cycle
        ACT_START_TMR0: begin
          tmr_nxt = dur_r;
          tmr_run_nxt = (dur_r != '0);
          tmr_exp_nxt = (dur_r == '0);
        end
        default: ;
      endcase
    end
    case (ms_r)
      MS_FREE: if (start_s) ms_nxt = MS_RUN;
      MS_RUN: if (!start_s) ms_nxt = MS_RAMP;
      MS_RAMP: begin
        if (start_s) ms_nxt = MS_RUN;
        else if (zspd_s) ms_nxt = MS_FREE;
      end
      default: ms_nxt = MS_FREE;
    endcase
    drv_nxt.run = (ms_nxt != MS_FREE);
    drv_nxt.ramp_down = (ms_nxt == MS_RAMP);
    drv_nxt.preset_sel = psel_nxt;
    drv_nxt.ref_pct = psel_nxt ? pre1_r : pre0_r;
  end

  // sequencer flops
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      scan_r <= '0;
      tick_r <= 1'b0;
      idx_r <= '0;
      tmr_r <= '0;
      tmr_run_r <= 1'b0;
      tmr_exp_r <= 1'b0;
      psel_r <= 1'b0;
      ms_r <= MS_FREE;
      drv_r <= '0;
    end else begin
      scan_r <= scan_nxt;
      tick_r <= tick_nxt;
      idx_r <= idx_nxt;
      tmr_r <= tmr_nxt;
      tmr_run_r <= tmr_run_nxt;
      tmr_exp_r <= tmr_exp_nxt;
      psel_r <= psel_nxt;
      ms_r <= ms_nxt;
      drv_r <= drv_nxt;
    end
  end

  // outputs straight from flops
  assign AWREADY_O = awrdy_r;
  assign WREADY_O = wrdy_r;
  assign BVALID_O = bvalid_r;
  assign BRESP_O = bresp_r;
  assign ARREADY_O = arrdy_r;
  assign RVALID_O = rvalid_r;
  assign RDATA_O = rdata_r;
  assign RRESP_O = rresp_r;
  assign DRV_O = drv_r;

  // checks
  idx_hold_false_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (en_r && idx_r < cnt_r && !fire) |=> (idx_r == $past(idx_r)))
    else $error("index moved without a true event");
  idx_step_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (fire && idx_r < cnt_r - IDX_W'(1)) |=> (idx_r == $past(idx_r) + IDX_W'(1)))
    else $error("index did not step after true event");
  idx_wrap_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (fire && idx_r == cnt_r - IDX_W'(1)) |=> (idx_r == '0))
    else $error("index did not wrap after last pair");
  mode_off_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !en_r |-> (!fire ##1 idx_r == '0))
    else $error("sequencer acted with mode off");
  zero_pairs_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (cnt_r == '0) |-> !fire)
    else $error("action with zero pairs");
  tick_single_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    tick_r |=> !tick_r)
    else $error("scan tick longer than one cycle");
  preset_sel_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (fire && cur_act == ACT_PRESET1) |=> (DRV_O.preset_sel && DRV_O.ref_pct == pre1_r))
    else $error("preset one not applied");
  timer_exp_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (tick_r && tmr_run_r && tmr_r == TMR_W'(1) && !(fire && cur_act == ACT_START_TMR0))
    |=> (tmr_exp_r && !tmr_run_r))
    else $error("timer did not expire");
  stop_ramp_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (ms_r == MS_RUN && !start_s) |=> (ms_r == MS_RAMP) ##1 DRV_O.ramp_down)
    else $error("stop did not ramp down");
endmodule

//--- hw/eas_pkg.sv
// eas_pkg: constants, types and register map of the event/action sequencer.
// assumes a 10 MHz controller clock and a 32-bit AXI4-Lite register bus.
package eas_pkg;
  // clock and scan timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCAN_INTERVAL_NS = 1000000;
  localparam int SCAN_CYCLES = (SCAN_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // sequencer sizing
  localparam int MAX_PAIRS = 20;
  localparam int IDX_W = 5;
  localparam int SEL_W = 8;
  localparam int PCT_W = 7;
  localparam int TMR_W = 16;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMER0 = 8'h04;
  localparam logic [7:0] OFS_PRESET0 = 8'h08;
  localparam logic [7:0] OFS_PRESET1 = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVENT_BASE = 8'h40;
  // actions sit above the last event word (0x8c), so the two arrays never share an address
  localparam logic [7:0] OFS_ACTION_BASE = 8'ha0;
  // control and status field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CNT_LSB = 8;
  localparam int ST_IDX_LSB = 0;
  localparam int ST_TMR_RUN_BIT = 8;
  localparam int ST_TMR_EXP_BIT = 9;
  localparam int ST_PRESET_BIT = 10;
  localparam int ST_MOTOR_LSB = 16;
  // reset values
  localparam logic [TMR_W-1:0] RST_TIMER0 = 16'h0000;
  localparam logic [PCT_W-1:0] RST_PRESET = 7'h00;
  localparam logic [SEL_W-1:0] RST_EVENT = 8'h00;
  localparam logic [SEL_W-1:0] RST_ACTION = 8'h01;
  // event selector codes
  localparam logic [SEL_W-1:0] EV_FALSE = 8'h00;
  localparam logic [SEL_W-1:0] EV_TRUE = 8'h01;
  localparam logic [SEL_W-1:0] EV_EXT_IN = 8'h02;
  localparam logic [SEL_W-1:0] EV_ON_REF = 8'h04;
  localparam logic [SEL_W-1:0] EV_TIMEOUT0 = 8'h1e;
  // action selector codes
  localparam logic [SEL_W-1:0] ACT_NONE = 8'h01;
  localparam logic [SEL_W-1:0] ACT_PRESET0 = 8'h0a;
  localparam logic [SEL_W-1:0] ACT_PRESET1 = 8'h0b;
  localparam logic [SEL_W-1:0] ACT_START_TMR0 = 8'h1d;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // motor control states, one-hot
  typedef enum logic [2:0] {
    MS_FREE = 3'b001,
    MS_RUN = 3'b010,
    MS_RAMP = 3'b100
  } eas_motor_e;
  // drive-facing outputs
  typedef struct packed {
    logic run;
    logic ramp_down;
    logic preset_sel;
    logic [PCT_W-1:0] ref_pct;
  } eas_drive_s;
endpackage

//--- verif/eas_sequencer_tb_top.sv
// eas_sequencer_tb_top: self-checking bench for the event/action sequencer.
// assumes the design runs with a short scan count; the bench drives every pin itself.
`timescale 1ns/1ps
module eas_sequencer_tb_top import eas_pkg::*; ;
  // short scan keeps each tick at eight clocks
  localparam int SCAN = 8;
  logic CLK_I = 1'b0;
  logic NRST_I;
  logic [7:0] AWADDR_I, ARADDR_I;
  logic [31:0] WDATA_I, RDATA_O;
  logic [3:0] WSTRB_I;
  logic AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
  logic [1:0] BRESP_O, RRESP_O;
  logic START_I, ZERO_SPEED_I, ON_REF_I, EXT_EVENT_I;
  eas_drive_s DRV_O;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;

  // 10 MHz clock and a free cycle count for spans
  always #50 CLK_I = ~CLK_I;
  always @(posedge CLK_I) cyc <= cyc + 1;

  eas_sequencer #(.SCAN_CNT(SCAN)) u_dut (
    .CLK_I(CLK_I), .NRST_I(NRST_I),
    .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
    .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
    .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
    .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
    .START_I(START_I), .ZERO_SPEED_I(ZERO_SPEED_I), .ON_REF_I(ON_REF_I),
    .EXT_EVENT_I(EXT_EVENT_I), .DRV_O(DRV_O)
  );

  // compare of data words
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // compare of bus response codes
  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one write; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    // the extra edge keeps bready from being lowered and raised in one step
    @(posedge CLK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= 1'b1;
    while (!(aw && w)) begin
      @(posedge CLK_I);
      if (!aw && AWREADY_O === 1'b1) begin
        AWVALID_I <= 1'b0;
        aw = 1'b1;
      end
      if (!w && WREADY_O === 1'b1) begin
        WVALID_I <= 1'b0;
        w = 1'b1;
      end
    end
    while (BVALID_O !== 1'b1) @(posedge CLK_I);
    chk_resp("bresp", er, BRESP_O);
    BREADY_I <= 1'b0;
  endtask

  // one read; rready held until the data edge
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= 1'b1;
    do @(posedge CLK_I); while (ARREADY_O !== 1'b1);
    ARVALID_I <= 1'b0;
    do @(posedge CLK_I); while (RVALID_O !== 1'b1);
    d = RDATA_O;
    RREADY_I <= 1'b0;
    chk_resp("rresp", er, RRESP_O);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, RESP_OKAY, d);
    chk(what, exp, d);
  endtask

  // masked look at the status word
  task automatic st_chk(input string what, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    rd(OFS_STATUS, RESP_OKAY, d);
    chk(what, exp, d & m);
  endtask

  // poll the index; bounded, since a stuck sequencer must not hang the run
  task automatic wait_idx(input logic [4:0] v);
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      rd(OFS_STATUS, RESP_OKAY, d);
      n++;
    end while (d[4:0] !== v && n < 40);
    chk("index", {27'h0, v}, {27'h0, d[4:0]});
  endtask

  task automatic t_regs();
    logic [31:0] d;
    rd_chk("ctrl", OFS_CTRL, 32'h0);
    rd_chk("timer0", OFS_TIMER0, 32'h0);
    rd_chk("event0", OFS_EVENT_BASE, {24'h0, EV_FALSE});
    rd_chk("action0", OFS_ACTION_BASE, {24'h0, ACT_NONE});
    rd_chk("status", OFS_STATUS, 32'h00010000);
    rd(8'h30, RESP_SLVERR, d);
    chk("unmapped", 32'h0, d);
    wr(8'h30, 32'h5, RESP_SLVERR);
    wr(OFS_EVENT_BASE + 8'h4c, {24'h0, EV_TIMEOUT0}, RESP_OKAY);
    rd_chk("event19", OFS_EVENT_BASE + 8'h4c, {24'h0, EV_TIMEOUT0});
    // the last event word must not spill into action word three
    rd_chk("action3", OFS_ACTION_BASE + 8'h0c, {24'h0, ACT_NONE});
    // a count above twenty is clamped to twenty
    wr(OFS_CTRL, 32'h1f00, RESP_OKAY);
    rd_chk("count clamp", OFS_CTRL, 32'h1400);
  endtask

  task automatic t_idle();
    wr(OFS_PRESET1, 32'h21, RESP_OKAY);
    wr(OFS_EVENT_BASE, {24'h0, EV_TRUE}, RESP_OKAY);
    wr(OFS_ACTION_BASE, {24'h0, ACT_PRESET1}, RESP_OKAY);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    repeat (4 * SCAN) @(posedge CLK_I);
    st_chk("idle zero pairs", 32'h41f, 32'h0);
    wr(OFS_CTRL, 32'h100, RESP_OKAY);
    repeat (4 * SCAN) @(posedge CLK_I);
    st_chk("mode off", 32'h41f, 32'h0);
    chk("drive sel off", 32'h0, {31'h0, DRV_O.preset_sel});
  endtask

  task automatic t_seq();
    logic [7:0] ev [4] = '{EV_TRUE, EV_ON_REF, EV_TIMEOUT0, EV_EXT_IN};
    logic [7:0] act [4] = '{ACT_PRESET1, ACT_START_TMR0, ACT_PRESET0, ACT_NONE};
    int t0;
    wr(OFS_PRESET0, 32'h3c, RESP_OKAY);
    wr(OFS_TIMER0, 32'h6, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_EVENT_BASE + 8'(4 * i), {24'h0, ev[i]}, RESP_OKAY);
      wr(OFS_ACTION_BASE + 8'(4 * i), {24'h0, act[i]}, RESP_OKAY);
    end
    wr(OFS_CTRL, 32'h401, RESP_OKAY);
    wait_idx(5'h01);
    chk("ref one", 32'h21, {25'h0, DRV_O.ref_pct});
    chk("sel one", 32'h1, {31'h0, DRV_O.preset_sel});
    repeat (4 * SCAN) @(posedge CLK_I);
    st_chk("false holds", 32'h1f, 32'h1);
    ON_REF_I <= 1'b1;
    wait_idx(5'h02);
    ON_REF_I <= 1'b0;
    st_chk("timer running", 32'h300, 32'h100);
    t0 = cyc;
    wait_idx(5'h03);
    chk("timer span", 32'h1, {31'h0, (cyc - t0) >= 5 * SCAN});
    // six ticks of run plus one tick to test the timeout event, plus the polling lag
    chk("timer span max", 32'h1, {31'h0, (cyc - t0) <= 8 * SCAN});
    st_chk("timer expired", 32'h300, 32'h200);
    chk("ref zero", 32'h3c, {25'h0, DRV_O.ref_pct});
    chk("sel zero", 32'h0, {31'h0, DRV_O.preset_sel});
    repeat (4 * SCAN) @(posedge CLK_I);
    st_chk("last waits", 32'h1f, 32'h3);
    EXT_EVENT_I <= 1'b1;
    repeat (4 * SCAN) @(posedge CLK_I);
    EXT_EVENT_I <= 1'b0;
    // after the wrap the true first event fires again and parks at pair two
    wait_idx(5'h01);
    chk("sel after wrap", 32'h1, {31'h0, DRV_O.preset_sel});
  endtask

  task automatic t_motor();
    START_I <= 1'b1;
    repeat (6) @(posedge CLK_I);
    chk("motor run", 32'h2, {30'h0, DRV_O.run, DRV_O.ramp_down});
    st_chk("state run", 32'h70000, 32'h20000);
    START_I <= 1'b0;
    repeat (6) @(posedge CLK_I);
    chk("motor ramp", 32'h3, {30'h0, DRV_O.run, DRV_O.ramp_down});
    repeat (3 * SCAN) @(posedge CLK_I);
    st_chk("state ramp", 32'h70000, 32'h40000);
    ZERO_SPEED_I <= 1'b1;
    repeat (6) @(posedge CLK_I);
    chk("motor free", 32'h0, {30'h0, DRV_O.run, DRV_O.ramp_down});
    st_chk("state free", 32'h70000, 32'h10000);
    ZERO_SPEED_I <= 1'b0;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    NRST_I = 1'b0;
    {AWADDR_I, ARADDR_I, WDATA_I} = '0;
    {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = '0;
    {START_I, ZERO_SPEED_I, ON_REF_I, EXT_EVENT_I} = '0;
    WSTRB_I = 4'hf;
    repeat (20) @(posedge CLK_I);
    NRST_I <= 1'b1;
    @(posedge CLK_I);
    t_regs();
    t_idle();
    t_seq();
    t_motor();
    test_done();
  end

  // watchdog: the whole run needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge CLK_I);
    mismatches++;
    test_done();
  end
endmodule
